// >>> hdl/fblo_pkg.sv
package fblo_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned WATCH_DELAY_ST   = 100;
    localparam int unsigned WATCH_DELAY_CYC  = WATCH_DELAY_ST;
    localparam int unsigned SYNC_STAGES      = 3;

    // ****************************************
    // Serial frame
    // ****************************************
    localparam int unsigned DATA_BITS        = 8;
    localparam int unsigned STOP_BITS        = 1;
    localparam int unsigned LOW_BITS         = 9;
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
    localparam logic [7:0]  BYTE_ACK         = 8'h55;
    localparam int unsigned CNT_W            = 20;
    localparam int unsigned DIV_W            = 16;
    localparam logic [15:0] DIV_RESET        = 16'h0000;

    // ****************************************
    // Address map
    // ****************************************
    localparam logic [23:0] WORK_LO          = 24'hFF8000;
    localparam logic [23:0] WORK_HI          = 24'hFF87FF;
    localparam logic [23:0] PROG_LO          = 24'hFF8800;
    localparam logic [23:0] PROG_HI          = 24'hFFBFFF;
    localparam logic [23:0] OVL_LO           = 24'hFFA000;
    localparam logic [23:0] OVL_HI           = 24'hFFAFFF;
    localparam logic [23:0] BLK_SPAN         = 24'h001000;
    localparam int unsigned BLK_CNT          = 8;
    localparam logic [7:0]  BLANK_BYTE       = 8'hFF;

    // ****************************************
    // Overlay select word fields
    // ****************************************
    localparam int unsigned OVL_ON_POS       = 3;
    localparam int unsigned OVL_SEL_LSB      = 0;
    localparam logic [7:0]  OVL_RESET        = 8'h00;
    localparam logic [7:0]  OVL_WMASK        = 8'h0F;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0]  OFS_OVL          = 4'h0;
    localparam logic [3:0]  OFS_SCTL         = 4'h1;
    localparam logic [3:0]  OFS_DIV          = 4'h2;
    localparam logic [3:0]  OFS_STAT         = 4'h3;
    localparam logic [3:0]  OFS_FCTL         = 4'h4;
    localparam int unsigned RX_ON_POS        = 4;
    localparam int unsigned TX_ON_POS        = 5;
    localparam int unsigned FPROG_POS        = 0;
    localparam int unsigned FERASE_POS       = 1;

    typedef enum logic [2:0] {
        FBLO_IDLE, FBLO_WAIT, FBLO_MEASURE, FBLO_SEND, FBLO_HANDSHAKE,
        FBLO_LOAD, FBLO_ERASE, FBLO_RUN
    } fblo_state_e;

endpackage

// >>> hdl/fblo_sync.sv
`timescale 1ns/1ps
module fblo_sync
    import fblo_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    // Pin
    input  wire logic pin_in,
    output logic      level_out
);
    logic [SYNC_STAGES-1:0] sh_reg;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sh_reg    <= '1;
            level_out <= 1'b1;
        end
        else
        begin
            sh_reg <= {sh_reg[SYNC_STAGES-2:0], pin_in};
            if (sh_reg[1] == sh_reg[2])
                level_out <= sh_reg[2];
        end
    end
endmodule

// >>> hdl/fblo_top.sv
// Behaviour
// - Measure zero byte low time, set baud
// - Frames are 8N1 both directions
// - Start watching about 100 states after reset
// - Send one zero byte after matching
// - Reserve work RAM FF8000-FF87FF for loader
// - Load program into FF8800-FFBFFF
// - Erase all flash if not blank
// - Clear rx/tx enables, keep divisor, tx high
// - Watchdog reset also exits boot mode
// - Block interrupts during program or erase
// - Support 19200 and 9600 at 8-25MHz
// - Overlay window fixed FFA000-FFAFFF
// - Select word picks one of eight blocks
// - Overlay RAM answers at both addresses
// - Overlay on protects all flash blocks, except the boot-mode erase
// - Clearing overlay restores flash mapping
// - Codes 000-111 map blocks zero to seven
`timescale 1ns/1ps
module fblo_top
    import fblo_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        wdt_reset_in,
    input  wire logic        boot_strap_pins_in,
    // Serial pins
    input  wire logic        rxd_in,
    output logic             txd_out,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [15:0]      reg_rdata_out,
    // Loader data stream
    input  wire logic [23:0] load_len_in,
    output logic [23:0]      ram_addr_out,
    output logic [7:0]       ram_wdata_out,
    output logic             ram_we_out,
    // Flash status and erase
    input  wire logic        flash_blank_in,
    input  wire logic        erase_done_in,
    output logic             erase_all_out,
    // CPU address remap
    input  wire logic [23:0] cpu_addr_in,
    input  wire logic [23:0] flash_base_in,
    output logic             ovl_hit_out,
    output logic [23:0]      ovl_ram_addr_out,
    output logic             work_area_lock_out,
    // Control outputs
    output logic             pe_protect_out,
    output logic             flash_prog_out,
    output logic             flash_erase_out,
    output logic             irq_block_out,
    output logic             boot_active_out,
    output logic             run_program_out
);

    // ****************************************
    // Registers
    // ****************************************
    fblo_state_e       state_reg;
    fblo_state_e       state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [DIV_W-1:0]  baud_divisor_word_reg;
    logic [7:0]        overlay_select_word_reg;
    logic [7:0]        serial_ctrl_word_reg;
    logic [1:0]        flash_ctl_one_reg;
    logic              boot_reg;
    logic              rx_prev_reg;
    logic [DIV_W-1:0]  bit_cnt_reg;
    logic [3:0]        bit_idx_reg;
    logic [9:0]        tx_sh_reg;
    logic              tx_busy_reg;
    logic [7:0]        rx_sh_reg;
    logic              rx_busy_reg;
    logic              rx_done_reg;
    logic [23:0]       load_idx_reg;
    logic [15:0]       rdata_reg;
    logic              rx_lvl;
    logic              wdt_exit_reg;

    fblo_sync u_rx_sync
    (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     (rxd_in),
        .level_out  (rx_lvl)
    );

    // ****************************************
    // Decode
    // ****************************************
    wire       rx_fall   = rx_prev_reg & ~rx_lvl;
    wire       rx_rise   = ~rx_prev_reg & rx_lvl;
    wire       ovl_on    = overlay_select_word_reg[OVL_ON_POS];
    wire [2:0] ovl_blk   = overlay_select_word_reg[OVL_SEL_LSB +: 3];
    wire [DIV_W-1:0] half_div = {1'b0, baud_divisor_word_reg[DIV_W-1:1]};
    wire       bit_tick  = (bit_cnt_reg == baud_divisor_word_reg);
    wire       half_tick = (bit_cnt_reg == half_div);
    wire       rx_on     = serial_ctrl_word_reg[RX_ON_POS];
    wire       tx_on     = serial_ctrl_word_reg[TX_ON_POS];
    wire       sel_ovl   = reg_addr_in == OFS_OVL;
    wire       sel_sctl  = reg_addr_in == OFS_SCTL;
    wire       sel_div   = reg_addr_in == OFS_DIV;
    wire       sel_stat  = reg_addr_in == OFS_STAT;
    wire       sel_fctl  = reg_addr_in == OFS_FCTL;
    wire [23:0] blk_lo   = flash_base_in + BLK_SPAN * {21'h0, ovl_blk};
    wire [23:0] blk_off  = cpu_addr_in - blk_lo;
    wire        in_blk   = (cpu_addr_in >= blk_lo) && (blk_off < BLK_SPAN);
    wire        in_win   = (cpu_addr_in >= OVL_LO) && (cpu_addr_in <= OVL_HI);
    wire        pe_req   = boot_reg && (state_reg == FBLO_ERASE);

    // ****************************************
    // Register read and write
    // ****************************************
    wire [15:0] rd_mux =
        sel_ovl  ? {8'h00, overlay_select_word_reg} :
        sel_sctl ? {8'h00, serial_ctrl_word_reg} :
        sel_div  ? baud_divisor_word_reg :
        sel_stat ? {12'h000, boot_reg, rx_lvl, tx_busy_reg, rx_busy_reg} :
        sel_fctl ? {14'h0, flash_ctl_one_reg} : 16'h0000;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_reg <= 16'h0000;
        else if (reg_rd_in)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 16'h0000;
    end
    assign reg_rdata_out = rdata_reg;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            overlay_select_word_reg <= OVL_RESET;
            flash_ctl_one_reg       <= 2'b00;
        end
        else if (wdt_reset_in)
        begin
            overlay_select_word_reg <= OVL_RESET;
            flash_ctl_one_reg       <= 2'b00;
        end
        else if (reg_wr_in && sel_ovl)
            overlay_select_word_reg <= reg_wdata_in[7:0] & OVL_WMASK;
        else if (reg_wr_in && sel_fctl)
            flash_ctl_one_reg <= reg_wdata_in[1:0];
    end

    // ****************************************
    // Overlay and protection
    // ****************************************
    assign ovl_hit_out      = ovl_on && (in_blk || in_win);
    assign ovl_ram_addr_out = (ovl_on && in_blk) ? (OVL_LO + blk_off) : cpu_addr_in;
    assign pe_protect_out   = ovl_on;
    assign flash_prog_out   = flash_ctl_one_reg[FPROG_POS] && !ovl_on;
    assign flash_erase_out  = (flash_ctl_one_reg[FERASE_POS] && !ovl_on) || pe_req;
    assign irq_block_out    = boot_reg || flash_prog_out || flash_erase_out;
    assign work_area_lock_out = boot_reg && (state_reg != FBLO_RUN)
                                && (cpu_addr_in >= WORK_LO) && (cpu_addr_in <= WORK_HI);
    assign boot_active_out  = boot_reg;
    assign run_program_out  = state_reg == FBLO_RUN;
    assign erase_all_out    = pe_req;

    // ****************************************
    // Boot sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            FBLO_IDLE:      state_next = FBLO_WAIT;
            FBLO_WAIT:      if (cnt_reg == CNT_W'(WATCH_DELAY_CYC))
                                state_next = FBLO_MEASURE;
            FBLO_MEASURE:   if (rx_rise && cnt_reg != '0)
                                state_next = FBLO_SEND;
            FBLO_SEND:      if (!tx_busy_reg && bit_idx_reg == 4'hF)
                                state_next = FBLO_HANDSHAKE;
            FBLO_HANDSHAKE: if (rx_done_reg && rx_sh_reg == BYTE_ACK)
                                state_next = FBLO_LOAD;
            FBLO_LOAD:      if (load_idx_reg == load_len_in
                                || load_idx_reg == PROG_HI - PROG_LO + 24'h1)
                                state_next = flash_blank_in ? FBLO_RUN : FBLO_ERASE;
            FBLO_ERASE:     if (erase_done_in)
                                state_next = FBLO_RUN;
            FBLO_RUN:       state_next = FBLO_RUN;
            default:        state_next = FBLO_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg    <= FBLO_IDLE;
            boot_reg     <= 1'b0;
            wdt_exit_reg <= 1'b0;
        end
        else if (wdt_reset_in)
        begin
            state_reg    <= FBLO_IDLE;
            boot_reg     <= 1'b0;
            wdt_exit_reg <= 1'b1;
        end
        else
        begin
            state_reg <= boot_reg ? state_next : FBLO_IDLE;
            if (state_reg == FBLO_IDLE && rx_prev_reg == rx_lvl)
                boot_reg <= boot_strap_pins_in && !wdt_exit_reg;
        end
    end

    // ****************************************
    // Rate measurement
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_reg               <= '0;
            baud_divisor_word_reg <= DIV_RESET;
            rx_prev_reg           <= 1'b1;
        end
        else
        begin
            rx_prev_reg <= rx_lvl;
            if (state_reg == FBLO_WAIT)
                cnt_reg <= (state_next == FBLO_MEASURE) ? '0 : cnt_reg + CNT_W'(1);
            else if (state_reg == FBLO_MEASURE)
            begin
                if (rx_fall)
                    cnt_reg <= CNT_W'(1);
                else if (!rx_lvl && cnt_reg != '0)
                    cnt_reg <= cnt_reg + CNT_W'(1);
                else if (rx_rise && cnt_reg != '0)
                    baud_divisor_word_reg <= DIV_W'(cnt_reg / LOW_BITS);
            end
            else
                cnt_reg <= '0;
        end
    end

    // ****************************************
    // Serial engine, 8N1
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            serial_ctrl_word_reg <= 8'h00;
            tx_sh_reg   <= 10'h3FF;
            tx_busy_reg <= 1'b0;
            bit_cnt_reg <= '0;
            bit_idx_reg <= 4'h0;
            rx_sh_reg   <= 8'h00;
            rx_busy_reg <= 1'b0;
            rx_done_reg <= 1'b0;
        end
        else
        begin
            rx_done_reg <= 1'b0;
            if (state_reg == FBLO_RUN)
                serial_ctrl_word_reg <= 8'h00;
            else if (state_reg == FBLO_SEND && !tx_busy_reg && bit_idx_reg == 4'h0)
            begin
                serial_ctrl_word_reg[TX_ON_POS] <= 1'b1;
                serial_ctrl_word_reg[RX_ON_POS] <= 1'b1;
                tx_sh_reg   <= {1'b1, BYTE_ZERO, 1'b0};
                tx_busy_reg <= 1'b1;
                bit_cnt_reg <= '0;
            end
            else if (tx_busy_reg)
            begin
                bit_cnt_reg <= bit_tick ? '0 : bit_cnt_reg + DIV_W'(1);
                if (bit_tick)
                begin
                    tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
                    bit_idx_reg <= bit_idx_reg + 4'h1;
                    if (bit_idx_reg == 4'(DATA_BITS + STOP_BITS))
                    begin
                        tx_busy_reg <= 1'b0;
                        bit_idx_reg <= 4'hF;
                    end
                end
            end
            else if (rx_on && !rx_busy_reg && rx_fall)
            begin
                rx_busy_reg <= 1'b1;
                bit_cnt_reg <= '0;
                bit_idx_reg <= 4'h0;
            end
            else if (rx_busy_reg)
            begin
                bit_cnt_reg <= bit_tick ? '0 : bit_cnt_reg + DIV_W'(1);
                if (bit_idx_reg == 4'h0 ? half_tick : bit_tick)
                begin
                    bit_cnt_reg <= '0;
                    bit_idx_reg <= bit_idx_reg + 4'h1;
                    if (bit_idx_reg != 4'h0 && bit_idx_reg <= 4'(DATA_BITS))
                        rx_sh_reg <= {rx_lvl, rx_sh_reg[7:1]};
                    if (bit_idx_reg == 4'(DATA_BITS + STOP_BITS))
                    begin
                        rx_busy_reg <= 1'b0;
                        rx_done_reg <= rx_lvl;
                    end
                end
            end
        end
    end
    assign txd_out = tx_sh_reg[0] | ~tx_busy_reg;

    // ****************************************
    // Program load into RAM
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            load_idx_reg  <= 24'h0;
            ram_addr_out  <= PROG_LO;
            ram_wdata_out <= 8'h00;
            ram_we_out    <= 1'b0;
        end
        else
        begin
            ram_we_out <= 1'b0;
            if (state_reg == FBLO_LOAD && rx_done_reg)
            begin
                ram_addr_out  <= PROG_LO + load_idx_reg;
                ram_wdata_out <= rx_sh_reg;
                ram_we_out    <= 1'b1;
                load_idx_reg  <= load_idx_reg + 24'h1;
            end
        end
    end

endmodule

// >>> sim/fblo_top_assertions.sv
`timescale 1ns/1ps
module fblo_top_assertions
    import fblo_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk_in,
    input wire logic        rst_b_in,
    input wire logic        wdt_reset_in,
    // Serial, loader and erase
    input wire logic        txd_out,
    input wire logic [23:0] ram_addr_out,
    input wire logic        ram_we_out,
    input wire logic        erase_done_in,
    input wire logic        erase_all_out,
    // Remap and control
    input wire logic [23:0] cpu_addr_in,
    input wire logic [23:0] flash_base_in,
    input wire logic        ovl_hit_out,
    input wire logic [23:0] ovl_ram_addr_out,
    input wire logic        work_area_lock_out,
    input wire logic        pe_protect_out,
    input wire logic        flash_prog_out,
    input wire logic        flash_erase_out,
    input wire logic        irq_block_out,
    input wire logic        boot_active_out,
    input wire logic        run_program_out
);
    // ********
    // Checks
    // ********
    logic [23:0] blk_ofs;
    logic        in_work;
    assign blk_ofs = cpu_addr_in - flash_base_in;
    assign in_work = (cpu_addr_in >= WORK_LO) && (cpu_addr_in <= WORK_HI);

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_run_txd_high:
        assert property (run_program_out |-> txd_out)
        else $error("txd low while loaded program runs");
    a_prot_no_prog:
        assert property (pe_protect_out |-> !flash_prog_out)
        else $error("program active under overlay protection");
    a_prot_no_erase:
        assert property (pe_protect_out && !erase_all_out |-> !flash_erase_out)
        else $error("erase active under overlay protection");
    a_hit_window:
        assert property (ovl_hit_out |-> ovl_ram_addr_out == {OVL_LO[23:12], cpu_addr_in[11:0]})
        else $error("overlay remap outside fixed window");
    a_hit_block:
        assert property (ovl_hit_out && cpu_addr_in[23:12] != OVL_LO[23:12]
            |-> pe_protect_out && blk_ofs < 24'h008000)
        else $error("overlay hit outside eight blocks or while off");
    a_irq_blocked:
        assert property (flash_prog_out || flash_erase_out || boot_active_out |-> irq_block_out)
        else $error("interrupts open during program, erase or boot");
    a_work_lock:
        assert property (boot_active_out && !run_program_out && in_work |-> work_area_lock_out)
        else $error("work area not locked during boot");
    a_ram_store:
        assert property (ram_we_out |-> (ram_addr_out >= PROG_LO && ram_addr_out <= PROG_HI)
            ##1 !ram_we_out)
        else $error("load store outside program area or too long");
    a_wdt_exit:
        assert property (wdt_reset_in |=> !boot_active_out [*3])
        else $error("boot mode kept after watchdog reset");
    a_erase_hold:
        assert property (erase_all_out && !erase_done_in && !wdt_reset_in |=> erase_all_out)
        else $error("erase dropped before done");

    c_hit: cover property (ovl_hit_out);
    c_erase: cover property ($rose(erase_all_out));
    c_run: cover property ($rose(run_program_out));
    c_store: cover property (ram_we_out);
endmodule

// >>> sim/fblo_host.sv
`timescale 1ns/1ps
module fblo_host
    import fblo_pkg::*;
#(
    parameter int BIT = 40
)
(
    // Clock and control
    input  wire logic       sys_clk_in,
    input  wire logic       start_in,
    input  wire logic [7:0] pat_in,
    input  wire logic [7:0] count_in,
    // Serial lines and seen byte
    input  wire logic       txd_in,
    output logic            rxd_out,
    output logic [7:0]      got_out,
    output logic            got_stb_out
);
    // ********
    // Host side
    // ********
    logic       seen;
    logic [7:0] rx;

    task automatic send(input logic [7:0] b);
        logic [8:0] fr;
        fr = {b, 1'b0};
        for (int i = 0; i < 9; i++)
        begin
            rxd_out <= fr[i];
            repeat (BIT) @(posedge sys_clk_in);
        end
        rxd_out <= 1'b1;
    endtask

    initial
    begin
        rxd_out = 1'b1;
        got_out = 8'h00;
        got_stb_out = 1'b0;
        forever
        begin
            do @(posedge sys_clk_in); while (!start_in);
            seen = 1'b0;
            while (!seen)
            begin
                send(BYTE_ZERO);
                for (int i = 0; i < 4 * BIT && !seen; i++)
                begin
                    @(posedge sys_clk_in);
                    seen = !txd_in;
                end
            end
            repeat (BIT / 2) @(posedge sys_clk_in);
            for (int i = 0; i < 9; i++)
            begin
                repeat (BIT) @(posedge sys_clk_in);
                if (i < 8) rx[i] = txd_in;
            end
            got_out <= rx;
            got_stb_out <= txd_in;
            @(posedge sys_clk_in);
            got_stb_out <= 1'b0;
            repeat (BIT) @(posedge sys_clk_in);
            send(BYTE_ACK);
            for (int i = 0; i < count_in; i++)
            begin
                repeat (2 * BIT) @(posedge sys_clk_in);
                send(pat_in + 8'(i));
            end
        end
    end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
    import fblo_pkg::*;
    localparam int BIT = 40;
    localparam int NLD = 4;
    typedef struct {logic [31:0] e; bit l;} fblo_exp_s;
    logic        sys_clk_in, rst_b_in, wdt_reset_in, boot_strap_pins_in, rxd_in, txd_out;
    logic        reg_wr_in, reg_rd_in, ram_we_out, flash_blank_in, erase_done_in;
    logic        erase_all_out, ovl_hit_out, work_area_lock_out, pe_protect_out;
    logic        flash_prog_out, flash_erase_out, irq_block_out, boot_active_out;
    logic        run_program_out, start, got_stb, rd_d, erased;
    logic [3:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [23:0] load_len_in, ram_addr_out, cpu_addr_in, flash_base_in, ovl_ram_addr_out;
    logic [7:0]  ram_wdata_out, pat, got;
    logic [11:0] off;
    int          num_errors, n_tests, seed;
    fblo_exp_s   rd_q[$], ram_q[$], host_q[$];

    fblo_top fblo_top_inst (.sys_clk_in, .rst_b_in, .wdt_reset_in, .boot_strap_pins_in,
        .rxd_in, .txd_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .load_len_in, .ram_addr_out, .ram_wdata_out, .ram_we_out, .flash_blank_in,
        .erase_done_in, .erase_all_out, .cpu_addr_in, .flash_base_in, .ovl_hit_out,
        .ovl_ram_addr_out, .work_area_lock_out, .pe_protect_out, .flash_prog_out,
        .flash_erase_out, .irq_block_out, .boot_active_out, .run_program_out);
    fblo_host #(.BIT(BIT)) fblo_host_inst (.sys_clk_in, .start_in(start), .pat_in(pat),
        .count_in(8'(NLD)), .txd_in(txd_out), .rxd_out(rxd_in), .got_out(got),
        .got_stb_out(got_stb));

    // ********
    // Helpers
    // ********
    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    function automatic fblo_exp_s ex(input logic [31:0] e, input bit l = 1'b0);
        return '{e, l};
    endfunction

    task automatic chk(input string nm, input fblo_exp_s x, input logic [31:0] s);
        n_tests++;
        if (!(s === x.e || (x.l && s === x.e - 32'h1)))
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x.e, s);
        end
    endtask

    task automatic summarize;
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input fblo_exp_s x);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        rd_q.push_back(x);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
    endtask

    task automatic at(input logic [23:0] a);
        @(posedge sys_clk_in);
        cpu_addr_in <= a;
        @(posedge sys_clk_in);
        #1;
    endtask

    task automatic do_reset(input logic strap, input logic blank, input int n);
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        boot_strap_pins_in <= strap;
        flash_blank_in <= blank;
        repeat (n) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
    endtask

    task automatic wdt_pulse;
        @(posedge sys_clk_in);
        wdt_reset_in <= 1'b1;
        @(posedge sys_clk_in);
        wdt_reset_in <= 1'b0;
        #1;
    endtask

    always @(posedge sys_clk_in)
    begin
        rd_d <= reg_rd_in;
        if (rd_d) chk("rdata", rd_q.pop_front(), 32'(reg_rdata_out));
        if (ram_we_out) chk("store", ram_q.pop_front(), {ram_addr_out, ram_wdata_out});
        if (got_stb) chk("host byte", host_q.pop_front(), 32'(got));
    end

    // ********
    // Scenarios
    // ********
    initial
    begin
        {rst_b_in, wdt_reset_in, reg_wr_in, reg_rd_in, erase_done_in, start} = '0;
        {boot_strap_pins_in, reg_addr_in, reg_wdata_in, cpu_addr_in, pat} = '0;
        {num_errors, n_tests} = '0;
        flash_blank_in = 1'b1;
        flash_base_in = 24'h100000;
        load_len_in = 24'(NLD);
        seed = $urandom(31);
        do_reset(1'b0, 1'b1, 5);
        rd(OFS_OVL, ex(32'h0));
        rd(OFS_DIV, ex(32'h0));
        rd(4'hF, ex(32'h0));
        for (int k = 0; k < BLK_CNT; k++)
        begin
            off = 12'($urandom);
            wr(OFS_OVL, 16'(8 + k));
            rd(OFS_OVL, ex(32'(8 + k)));
            at(flash_base_in + 24'(k) * BLK_SPAN + 24'(off));
            chk("hit", ex(32'h1), 32'(ovl_hit_out));
            chk("remap", ex(32'(OVL_LO + 24'(off))), 32'(ovl_ram_addr_out));
            at(cpu_addr_in ^ BLK_SPAN);
            chk("miss", ex(32'h0), 32'(ovl_hit_out));
            at(OVL_LO + 24'(off));
            chk("win", ex(32'h1), 32'(ovl_hit_out));
        end
        wr(OFS_FCTL, 16'h0003);
        at(flash_base_in + 24'h007000);
        chk("prog", ex(32'h0), 32'(flash_prog_out));
        chk("erase", ex(32'h0), 32'(flash_erase_out));
        chk("protect", ex(32'h1), 32'(pe_protect_out));
        wr(OFS_OVL, 16'h0007);
        at(cpu_addr_in);
        chk("unmap", ex(32'h0), 32'(ovl_hit_out));
        chk("prog", ex(32'h1), 32'(flash_prog_out));
        chk("irq", ex(32'h1), 32'(irq_block_out));
        wr(OFS_FCTL, 16'h0000);
        wr(OFS_OVL, 16'hFFFF);
        rd(OFS_OVL, ex(32'(OVL_WMASK)));
        wdt_pulse();
        rd(OFS_OVL, ex(32'h0));
        for (int b = 0; b < 2; b++)
        begin
            pat <= 8'($urandom);
            do_reset(1'b1, b[0], 20);
            repeat (10) @(posedge sys_clk_in);
            start <= 1'b1;
            erased = 1'b0;
            at(WORK_LO + 24'($urandom % 2048));
            start <= 1'b0;
            chk("lock", ex(32'h1), 32'(work_area_lock_out));
            chk("irq", ex(32'h1), 32'(irq_block_out));
            for (int i = 0; i < NLD; i++) ram_q.push_back(ex({PROG_LO + 24'(i), pat + 8'(i)}));
            host_q.push_back(ex(32'(BYTE_ZERO)));
            for (int t = 0; t < 20000 && run_program_out !== 1'b1; t++)
            begin
                @(posedge sys_clk_in);
                erased = erased | erase_all_out;
                erase_done_in <= erase_all_out && !erase_done_in;
            end
            if (run_program_out !== 1'b1)
            begin
                num_errors++;
                summarize();
            end
            chk("erased", ex(32'(b == 0)), 32'(erased));
            at(cpu_addr_in);
            chk("lock", ex(32'h0), 32'(work_area_lock_out));
            chk("txd", ex(32'h1), 32'(txd_out));
            rd(OFS_SCTL, ex(32'h0));
            rd(OFS_DIV, ex(32'(BIT), 1'b1));
            wdt_pulse();
            chk("boot", ex(32'h0), 32'(boot_active_out));
        end
        chk("pending", ex(32'h0), 32'(rd_q.size() + ram_q.size() + host_q.size()));
        summarize();
    end
endmodule

bind fblo_top fblo_top_assertions fblo_top_assertions_inst (.sys_clk_in, .rst_b_in,
    .wdt_reset_in, .txd_out, .ram_addr_out, .ram_we_out, .erase_done_in, .erase_all_out,
    .cpu_addr_in, .flash_base_in, .ovl_hit_out, .ovl_ram_addr_out, .work_area_lock_out,
    .pe_protect_out, .flash_prog_out, .flash_erase_out, .irq_block_out, .boot_active_out,
    .run_program_out);
